// *** rtl/dma_pkg.sv ***
// Shared constants and types for the two-channel transfer engine.
package dma_pkg;
  // -------------------------------------------------------------------
  // Sizes
  // -------------------------------------------------------------------
  localparam int ADDR_W = 32;  // Bus address width.
  localparam int DATA_W = 32;  // Bus data width.
  localparam int KIND_W = 3;   // Endpoint kind code width.

  // -------------------------------------------------------------------
  // Endpoint kinds
  // -------------------------------------------------------------------
  localparam logic [2:0] KIND_EXT_MEM  = 3'h0;  // External memory.
  localparam logic [2:0] KIND_MMIO     = 3'h1;  // Memory-mapped device.
  localparam logic [2:0] KIND_ACK_DEV  = 3'h2;  // Device on ack strobe.
  localparam logic [2:0] KIND_CHIP_MEM = 3'h3;  // On-chip memory.
  localparam logic [2:0] KIND_PERIPH   = 3'h4;  // Peripheral register.
  localparam logic [2:0] KIND_BARRED   = 3'h5;  // Controller, bus-state
                                                // unit, break unit, cache,
                                                // ethernet dma/mac units.

  // -------------------------------------------------------------------
  // Reset values and channel numbers
  // -------------------------------------------------------------------
  localparam logic CH0          = 1'b0;  // Channel 0.
  localparam logic CH1          = 1'b1;  // Channel 1.
  localparam logic PRIO_RST_HI  = CH1;   // Channel ahead after reset.
  localparam logic SCHEME_FIXED = 1'b0;  // Fixed order, channel 0 first.

  // Transfer sequencer states.
  typedef enum logic [1:0] {
    ST_IDLE   = 2'b00,
    ST_SINGLE = 2'b01,
    ST_READ   = 2'b10,
    ST_WRITE  = 2'b11
  } xfer_state_t;
endpackage

// *** rtl/arb_if.sv ***
// Link between the transfer sequencer and the channel arbiter.
`timescale 1ns/1ps
interface arb_if;
  logic [1:0] pending;      // Pending enabled requests per channel.
  logic       idle;         // Sequencer may start a transfer.
  logic       grant_valid;  // A channel is granted this cycle.
  logic       grant_ch;     // Granted channel.
  logic       done;         // A transfer completes this cycle.
  logic       done_ch;      // Channel whose transfer completes.
  logic       scheme;       // Priority scheme select.
  logic       hi_ch;        // Channel currently ahead.

  modport core (output pending, idle, done, done_ch, scheme,
                input  grant_valid, grant_ch, hi_ch);
  modport arb  (input  pending, idle, done, done_ch, scheme,
                output grant_valid, grant_ch, hi_ch);
endinterface

// *** rtl/channel_arbiter.sv ***
// Fixed or round-robin arbiter between the two channels.
`timescale 1ns/1ps
module channel_arbiter (
  // Clock, reset and enable.
  input wire logic CLK,
  input wire logic RST,
  input wire logic CE,
  // Sequencer side.
  arb_if.arb       a
);
  import dma_pkg::*;

  logic hi_reg;   // Channel that wins a tie in round-robin.
  logic hi_next;  // Next value of hi_reg.

  // -------------------------------------------------------------------
  // Grant
  // -------------------------------------------------------------------
  // Grants only while the sequencer is idle.
  always_comb begin
    a.grant_valid = a.idle && (a.pending != 2'b00);
    if (a.pending != 2'b11) begin
      a.grant_ch = a.pending[CH1];
    end else if (a.scheme == SCHEME_FIXED) begin
      a.grant_ch = CH0;
    end else begin
      a.grant_ch = hi_reg;
    end
  end

  // -------------------------------------------------------------------
  // Round-robin state
  // -------------------------------------------------------------------
  // Each completion in round-robin puts the channel that did not finish ahead; fixed order keeps the lead.
  always_comb begin
    hi_next = hi_reg;
    if (a.done && a.scheme != SCHEME_FIXED) begin
      hi_next = ~a.done_ch;
    end
  end

  // Registers the lead; reset puts channel 1 ahead.
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      hi_reg <= PRIO_RST_HI;
    end else if (CE) begin
      hi_reg <= hi_next;
    end
  end

  assign a.hi_ch = hi_reg;

  // -------------------------------------------------------------------
  // Checks
  // -------------------------------------------------------------------
  property p_rr_low;
    @(posedge CLK) disable iff (RST)
      (CE && a.done && a.scheme) |=> (hi_reg == !$past(a.done_ch));
  endproperty
  a_rr_low: assert property (p_rr_low)
    else $error("Finished channel did not drop to low priority.");

  property p_rr_keep;
    @(posedge CLK) disable iff (RST)
      (CE && a.done && a.scheme && hi_reg != a.done_ch) |=> $stable(hi_reg);
  endproperty
  a_rr_keep: assert property (p_rr_keep)
    else $error("Priority toggled although finisher was already low.");

  property p_fixed_tie;
    @(posedge CLK) disable iff (RST)
      (a.grant_valid && a.pending == 2'b11 && !a.scheme) |-> !a.grant_ch;
  endproperty
  a_fixed_tie: assert property (p_fixed_tie)
    else $error("Fixed mode did not favour channel 0.");

  property p_rr_tie;
    @(posedge CLK) disable iff (RST)
      (a.grant_valid && a.pending == 2'b11 && a.scheme)
        |-> (a.grant_ch == hi_reg);
  endproperty
  a_rr_tie: assert property (p_rr_tie)
    else $error("Round-robin tie not given to leading channel.");

  property p_lone;
    @(posedge CLK) disable iff (RST)
      (a.idle && a.pending == 2'b01) |-> (a.grant_valid && !a.grant_ch);
  endproperty
  a_lone: assert property (p_lone)
    else $error("Lone channel 0 request was not granted.");
endmodule

// *** rtl/dma_core.sv ***
// Two-channel transfer engine with single and dual address modes.
`timescale 1ns/1ps
module dma_core #(
  parameter int AW = dma_pkg::ADDR_W,  // Address width.
  parameter int DW = dma_pkg::DATA_W   // Data width.
) (
  // Clock, reset and enable.
  input  wire logic                       CLK,
  input  wire logic                       RST,
  input  wire logic                       CE,
  // Shared scheme select, then channel setup, one bit or field per channel.
  input  wire logic                       PRIORITY_SCHEME_SELECT,
  input  wire logic [1:0]                 CH_ENABLE,
  input  wire logic [1:0]                 CH_SINGLE_MODE,
  input  wire logic [1:0]                 CH_EXT_TRIGGER,
  input  wire logic [1:0]                 ACK_CYCLE_SELECT,
  input  wire logic [1:0]                 CH_SIZE_OK,
  input  wire logic [1:0][dma_pkg::KIND_W-1:0] CH_SRC_KIND,
  input  wire logic [1:0][dma_pkg::KIND_W-1:0] CH_DST_KIND,
  input  wire logic [1:0][AW-1:0]         CH_SRC_ADDR,
  input  wire logic [1:0][AW-1:0]         CH_DST_ADDR,
  // Transfer triggers.
  input  wire logic [1:0]                 EXTERNAL_TRANSFER_REQUEST,
  input  wire logic [1:0]                 INTERNAL_TRIGGER,
  // System bus master.
  output logic [AW-1:0]                   BUS_ADDR,
  output logic                            BUS_RD,
  output logic                            BUS_WR,
  output logic                            BUS_WDATA_OE,
  output logic [DW-1:0]                   BUS_WDATA,
  input  wire logic [DW-1:0]              BUS_RDATA,
  input  wire logic                       BUS_READY,
  // Acknowledge strobes and status.
  output logic [1:0]                      TRANSFER_ACK_STROBE,
  output logic [1:0]                      XFER_DONE,
  output logic [1:0]                      CFG_ERROR
);
  import dma_pkg::*;

  // -------------------------------------------------------------------
  // State
  // -------------------------------------------------------------------
  xfer_state_t   state_reg, state_next;  // Sequencer state.
  logic          ch_reg, ch_next;        // Channel being served.
  logic [1:0]    pend_reg, pend_next;    // Requests waiting.
  logic [AW-1:0] addr_reg, addr_next;    // Bus address.
  logic          rd_reg, rd_next;        // Read strobe.
  logic          wr_reg, wr_next;        // Write strobe.
  logic          oe_reg, oe_next;        // Data drive enable.
  logic [DW-1:0] hold_reg, hold_next;    // Holding buffer.
  logic [1:0]    ack_reg, ack_next;      // Acknowledge strobes.
  logic [1:0]    done_reg, done_next;    // Completion pulses.
  logic [1:0]    err_reg, err_next;      // Setup fault levels.
  logic [1:0]    legal;                  // Setup accepted.
  logic [1:0]    trig;                   // Chosen trigger.
  logic          finish;                 // Last cycle completes.

  arb_if a ();

  // Returns 1 when the end is outside the chip.
  function automatic logic is_ext(input logic [KIND_W-1:0] k);
    return k == KIND_EXT_MEM || k == KIND_MMIO || k == KIND_ACK_DEV;
  endfunction

  // Returns 1 when a channel setup is allowed.
  function automatic logic check(input logic single,
                                 input logic ext_trig,
                                 input logic size_ok,
                                 input logic [KIND_W-1:0] s,
                                 input logic [KIND_W-1:0] d);
    logic ok;
    ok = 1'b0;
    if (single) begin
      // ack device with memory or mmio
      ok = is_ext(s) && is_ext(d) &&
           ((s == KIND_ACK_DEV) != (d == KIND_ACK_DEV));
      ok = ok && ext_trig;
    end else begin
      ok = s != KIND_ACK_DEV && d != KIND_ACK_DEV &&
           s != KIND_BARRED && d != KIND_BARRED;
      if (s == KIND_PERIPH || d == KIND_PERIPH) begin
        ok = ok && size_ok;
      end
    end
    return ok;
  endfunction

  // -------------------------------------------------------------------
  // Setup check and triggers
  // -------------------------------------------------------------------
  // Checks both channels and picks each one's trigger source.
  always_comb begin
    for (int i = 0; i < 2; i++) begin
      legal[i] = check(CH_SINGLE_MODE[i], CH_EXT_TRIGGER[i], CH_SIZE_OK[i],
                       CH_SRC_KIND[i], CH_DST_KIND[i]);
      trig[i]  = CH_EXT_TRIGGER[i] ? EXTERNAL_TRANSFER_REQUEST[i]
                                   : INTERNAL_TRIGGER[i];
    end
  end

  // -------------------------------------------------------------------
  // Arbiter hookup
  // -------------------------------------------------------------------
  // Completion is the ready of the last bus cycle of a transfer.
  assign finish    = BUS_READY &&
                     (state_reg == ST_SINGLE || state_reg == ST_WRITE);
  assign a.pending = pend_reg;
  assign a.idle    = state_reg == ST_IDLE;
  assign a.done    = CE && finish;
  assign a.done_ch = ch_reg;
  assign a.scheme  = PRIORITY_SCHEME_SELECT;

  channel_arbiter u_arb (
    .CLK (CLK),
    .RST (RST),
    .CE  (CE),
    .a   (a.arb)
  );

  // -------------------------------------------------------------------
  // Sequencer next state
  // -------------------------------------------------------------------
  // Runs one transfer: one bus cycle in single mode, two in dual.
  always_comb begin
    state_next = state_reg;
    ch_next    = ch_reg;
    addr_next  = addr_reg;
    rd_next    = rd_reg;
    wr_next    = wr_reg;
    oe_next    = oe_reg;
    hold_next  = hold_reg;
    ack_next   = ack_reg;
    done_next  = 2'b00;
    err_next   = CH_ENABLE & ~legal;
    // loser stays pending; new request wins over clear
    pend_next  = pend_reg;
    if (a.grant_valid) begin
      pend_next[a.grant_ch] = 1'b0;
    end
    pend_next = pend_next | (CH_ENABLE & legal & trig);
    case (state_reg)
      // Waits for a grant and opens the first bus cycle.
      ST_IDLE: begin
        if (a.grant_valid) begin
          ch_next = a.grant_ch;
          ack_next = 2'b00;
          if (CH_SINGLE_MODE[a.grant_ch]) begin
            // ack and address in one cycle
            state_next = ST_SINGLE;
            ack_next[a.grant_ch] = 1'b1;
            if (CH_SRC_KIND[a.grant_ch] == KIND_ACK_DEV) begin
              addr_next = CH_DST_ADDR[a.grant_ch];
              wr_next   = 1'b1;
            end else begin
              addr_next = CH_SRC_ADDR[a.grant_ch];
              rd_next   = 1'b1;
            end
          end else begin
            state_next = ST_READ;
            addr_next  = CH_SRC_ADDR[a.grant_ch];
            rd_next    = 1'b1;
            ack_next[a.grant_ch] = ~ACK_CYCLE_SELECT[a.grant_ch];
          end
        end
      end
      // Single address cycle ends on ready.
      ST_SINGLE: begin
        if (BUS_READY) begin
          state_next       = ST_IDLE;
          rd_next          = 1'b0;
          wr_next          = 1'b0;
          ack_next         = 2'b00;
          done_next[ch_reg] = 1'b1;
        end
      end
      // Read cycle: fetch into the buffer, then open the write.
      ST_READ: begin
        if (BUS_READY) begin
          hold_next  = BUS_RDATA;
          state_next = ST_WRITE;
          rd_next    = 1'b0;
          wr_next    = 1'b1;
          oe_next    = 1'b1;
          addr_next  = CH_DST_ADDR[ch_reg];
          ack_next   = 2'b00;
          ack_next[ch_reg] = ACK_CYCLE_SELECT[ch_reg];
        end
      end
      // Write cycle drives the buffer to the destination.
      ST_WRITE: begin
        if (BUS_READY) begin
          state_next       = ST_IDLE;
          wr_next          = 1'b0;
          oe_next          = 1'b0;
          ack_next         = 2'b00;
          done_next[ch_reg] = 1'b1;
        end
      end
      default: begin
        state_next = ST_IDLE;
      end
    endcase
  end

  // -------------------------------------------------------------------
  // Sequencer registers
  // -------------------------------------------------------------------
  // Holds all sequencer state; frozen while the enable is low.
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      state_reg <= ST_IDLE;
      ch_reg    <= CH0;
      pend_reg  <= 2'b00;
      addr_reg  <= '0;
      rd_reg    <= 1'b0;
      wr_reg    <= 1'b0;
      oe_reg    <= 1'b0;
      hold_reg  <= '0;
      ack_reg   <= 2'b00;
      done_reg  <= 2'b00;
      err_reg   <= 2'b00;
    end else if (CE) begin
      state_reg <= state_next;
      ch_reg    <= ch_next;
      pend_reg  <= pend_next;
      addr_reg  <= addr_next;
      rd_reg    <= rd_next;
      wr_reg    <= wr_next;
      oe_reg    <= oe_next;
      hold_reg  <= hold_next;
      ack_reg   <= ack_next;
      done_reg  <= done_next;
      err_reg   <= err_next;
    end
  end

  // Outputs straight from registers.
  assign BUS_ADDR            = addr_reg;
  assign BUS_RD              = rd_reg;
  assign BUS_WR              = wr_reg;
  assign BUS_WDATA_OE        = oe_reg;
  assign BUS_WDATA           = hold_reg;
  assign TRANSFER_ACK_STROBE = ack_reg;
  assign XFER_DONE           = done_reg;
  assign CFG_ERROR           = err_reg;

  // -------------------------------------------------------------------
  // Checks
  // -------------------------------------------------------------------
  property p_single_cycle;
    @(posedge CLK) disable iff (RST)
      (state_reg == ST_SINGLE) |-> (ack_reg[ch_reg] && (rd_reg ^ wr_reg));
  endproperty
  a_single_cycle: assert property (p_single_cycle)
    else $error("Single cycle lacks ack or bus strobe.");

  property p_single_ext;
    @(posedge CLK) disable iff (RST)
      (state_reg == ST_SINGLE) |-> CH_EXT_TRIGGER[ch_reg];
  endproperty
  a_single_ext: assert property (p_single_ext)
    else $error("Single transfer started without external trigger.");

  property p_read_then_write;
    @(posedge CLK) disable iff (RST)
      (CE && state_reg == ST_READ && BUS_READY)
        |=> (state_reg == ST_WRITE && wr_reg && !rd_reg
             && hold_reg == $past(BUS_RDATA));
  endproperty
  a_read_then_write: assert property (p_read_then_write)
    else $error("Dual read not followed by write of fetched data.");

  property p_hold;
    @(posedge CLK) disable iff (RST)
      (state_reg == ST_WRITE && $past(state_reg) == ST_WRITE)
        |-> $stable(hold_reg);
  endproperty
  a_hold: assert property (p_hold)
    else $error("Holding buffer changed during write cycle.");

  property p_ack_phase;
    @(posedge CLK) disable iff (RST)
      (state_reg == ST_READ || state_reg == ST_WRITE)
        |-> (ack_reg[ch_reg] == ((state_reg == ST_WRITE)
                                 == ACK_CYCLE_SELECT[ch_reg]));
  endproperty
  a_ack_phase: assert property (p_ack_phase)
    else $error("Dual ack in wrong cycle.");

  property p_pend_kept;
    @(posedge CLK) disable iff (RST)
      (CE && a.grant_valid && pend_reg == 2'b11)
        |=> pend_reg[!$past(a.grant_ch)];
  endproperty
  a_pend_kept: assert property (p_pend_kept)
    else $error("Losing channel request was dropped.");
endmodule

// *** testbench/bus_partner.sv ***
// Far-side model: memories, mapped devices and ack-strobed devices.
`timescale 1ns/1ps
module bus_partner #(
  parameter logic [31:0] KEY = 32'h5a5a_0000  // Memory word pattern.
) (
  // Clock and reset.
  input  wire logic        clk,
  input  wire logic        rst,
  // Bus from the engine.
  input  wire logic [31:0] addr,
  input  wire logic        rd,
  input  wire logic        wr,
  input  wire logic        oe,
  input  wire logic [1:0]  ack,
  // Bench knobs.
  input  wire logic        stall,
  input  wire logic [31:0] dev,
  // Answer to the engine.
  output logic [31:0]      rdata,
  output logic             ready
);
  // ---------------------------------------------------------------
  // Data bus
  // ---------------------------------------------------------------
  logic [31:0] last_reg;  // Last value seen on the data bus.

  // A released bus shows a changing value, never the old word.
  // ack device drives data
  always_comb begin
    if (rd) begin
      rdata = addr ^ KEY;
    end else if (wr && !oe && |ack) begin
      rdata = dev;
    end else begin
      rdata = ~last_reg;
    end
  end

  // Remembers the bus so the idle pattern keeps moving.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      last_reg <= 32'h0000_0000;
    end else begin
      last_reg <= rdata;
    end
  end

  // Random wait states end each cycle slowly or promptly.
  assign ready = (rd | wr) & ~stall;
endmodule

// *** testbench/dma_priority_and_address_modes_tb.sv ***
// Self-checking bench for the two-channel transfer engine.
`timescale 1ns/1ps
module dma_priority_and_address_modes_tb;
  import dma_pkg::*;
  localparam logic [31:0] KEY = 32'h5a5a_0000;  // Memory pattern.
  logic            clk, rst, ce, jit, scheme, stall, rd, wr, oe, ready;
  logic [1:0]      en, single, ext, ackc, size_ok, ereq, ireq;
  logic [1:0]      ack, done, done_q, cerr;
  logic [1:0][2:0] sk, dk;       // Endpoint kinds per channel.
  logic [1:0][31:0] sa, da;      // Endpoint addresses.
  logic [31:0]     addr, wdata, rdata, dev;
  logic [67:0]     cyc_q[$];     // Expected bus cycles.
  logic            ch_q[$];      // Expected finishing channels.
  logic [8:0]      bad[7];       // Illegal setups.
  int              failures, cmp_count, seed, i;

  dma_core u_dut (.CLK(clk), .RST(rst), .CE(ce),
    .PRIORITY_SCHEME_SELECT(scheme), .CH_ENABLE(en),
    .CH_SINGLE_MODE(single), .CH_EXT_TRIGGER(ext),
    .ACK_CYCLE_SELECT(ackc), .CH_SIZE_OK(size_ok), .CH_SRC_KIND(sk),
    .CH_DST_KIND(dk), .CH_SRC_ADDR(sa), .CH_DST_ADDR(da),
    .EXTERNAL_TRANSFER_REQUEST(ereq), .INTERNAL_TRIGGER(ireq),
    .BUS_ADDR(addr), .BUS_RD(rd), .BUS_WR(wr), .BUS_WDATA_OE(oe),
    .BUS_WDATA(wdata), .BUS_RDATA(rdata), .BUS_READY(ready),
    .TRANSFER_ACK_STROBE(ack), .XFER_DONE(done), .CFG_ERROR(cerr));

  bus_partner #(.KEY(KEY)) u_far (.clk(clk), .rst(rst), .addr(addr),
    .rd(rd), .wr(wr), .oe(oe), .ack(ack), .stall(stall), .dev(dev),
    .rdata(rdata), .ready(ready));

  // Free-running clock.
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // Compares one value and counts it.
  task automatic check(string what, logic [67:0] seen, logic [67:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      failures++;
      $display("wrong value %s exp %h seen %h", what, exp, seen);
    end
  endtask

  // Prints the counts and the verdict, then stops.
  task automatic end_of_test();
    $display("compares %0d failures %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  // Sets up one channel: {single, ext, size ok, src kind, dst kind}.
  task automatic cfg(logic c, logic [8:0] v, logic a);
    {single[c], ext[c], size_ok[c], sk[c], dk[c]} <= v;
    ackc[c] <= a;
    sa[c] <= $random(seed);
    da[c] <= $random(seed);
  endtask

  // Notes the bus cycles one transfer of channel c must make.
  task automatic note(logic c);
    logic [1:0] b;
    b = 2'b01 << c;
    if (single[c] && sk[c] == KIND_ACK_DEV) begin
      cyc_q.push_back({2'b10, b, da[c], dev});
    end else if (single[c]) begin
      cyc_q.push_back({2'b00, b, sa[c], 32'h0000_0000});
    end else begin
      cyc_q.push_back({2'b00, ackc[c] ? 2'b00 : b, sa[c], 32'h0000_0000});
      cyc_q.push_back({2'b11, ackc[c] ? b : 2'b00, da[c], sa[c] ^ KEY});
    end
    ch_q.push_back(c);
  endtask

  // Pulses requests of mask m and waits for the noted traffic.
  task automatic go(logic [1:0] m, logic first);
    int n;
    dev <= $random(seed);
    repeat (2) @(posedge clk);
    check("config error", cerr, 68'h0);
    if (m == 2'b11) begin
      note(first);
      note(~first);
    end else begin
      note(m[1]);
    end
    ereq <= m;
    ireq <= m;
    @(posedge clk);
    ereq <= 2'b00;
    ireq <= 2'b00;
    for (n = 0; n < 200 && (cyc_q.size() > 0 || ch_q.size() > 0); n++) begin
      @(posedge clk);
    end
    check("queue drained", cyc_q.size() + ch_q.size(), 68'h0);
    repeat (2) @(posedge clk);
  endtask

  // Random wait states from the far side; the enable jitters while jit is
  // set, so that frozen cycles must neither end a bus cycle nor lose state.
  always @(posedge clk) begin
    stall <= 1'($random(seed));
    ce    <= !jit || 1'($random(seed));
  end

  // Compares each finished bus cycle and done pulse with the oldest note.
  // A bus cycle only ends on an enabled edge; a done pulse held by a low
  // enable is counted once, at its rising edge.
  always @(posedge clk) begin
    if (!rst && ce && ready && (rd || wr)) begin
      if (cyc_q.size() == 0) begin
        check("unexpected bus cycle", 68'h1, 68'h0);
      end else begin
        check("bus cycle", {wr, oe, ack, addr,
          wr ? (oe ? wdata : rdata) : 32'h0000_0000},
          cyc_q.pop_front());
      end
    end
    for (int c = 0; c < 2; c++) begin
      if (!rst && done[c] === 1'b1 && done_q[c] !== 1'b1) begin
        if (ch_q.size() == 0) begin
          check("unexpected done", 68'h1, 68'h0);
        end else begin
          check("done channel", c,
                ch_q.pop_front());
        end
      end
    end
    done_q <= rst ? 2'b00 : done;
  end

  // Cuts a hang short.
  initial begin
    repeat (20000) @(posedge clk);
    failures++;
    end_of_test();
  end

  // Main sequence.
  initial begin
    seed = 32'h6e22_6c82;
    {rst, scheme, stall, jit, en, single, ext, ackc, size_ok} = 0;
    {ereq, ireq, sk, dk, sa, da, dev, failures, cmp_count} = 0;
    rst = 1'b1;
    ce = 1'b1;
    bad = '{9'h150, 9'h1d2, 9'h1c1, 9'h1da, 9'h0d0, 9'h0c5, 9'h0a0};
    repeat (16) @(posedge clk);
    check("outputs in reset", {rd, wr, ack, done, cerr}, 68'h0);
    rst <= 1'b0;
    en <= 2'b11;
    scheme <= 1'b1;
    cfg(0, 9'h0c1, 1'b0);
    cfg(1, 9'h0cb, 1'b1);
    go(2'b11, 1'b1);
    go(2'b01, 1'b0);
    go(2'b11, 1'b1);
    $display("round-robin test done");
    scheme <= 1'b0;
    // Fixed order runs with a jittering clock enable.
    jit <= 1'b1;
    cfg(0, 9'h05c, 1'b1);
    cfg(1, 9'h060, 1'b0);
    go(2'b11, 1'b0);
    go(2'b11, 1'b0);
    go(2'b10, 1'b1);
    $display("fixed priority test done");
    scheme <= 1'b1;
    jit <= 1'b0;
    cfg(0, 9'h1d0, 1'b0);
    cfg(1, 9'h1ca, 1'b0);
    go(2'b11, 1'b1);
    $display("single address test done");
    en <= 2'b01;
    for (i = 0; i < 7; i++) begin
      cfg(0, bad[i], 1'b0);
      repeat (3) @(posedge clk);
      check("setup refused", cerr,
            68'h1);
      ereq <= 2'b01;
      ireq <= 2'b01;
      @(posedge clk);
      ereq <= 2'b00;
      ireq <= 2'b00;
      repeat (8) @(posedge clk);
    end
    $display("illegal setup test done");
    // Channel 1 finishes last so that channel 0 leads before the reset.
    en <= 2'b11;
    cfg(0, 9'h0c1, 1'b0);
    go(2'b10, 1'b1);
    // mid-run reset puts channel 1 ahead again
    rst <= 1'b1;
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    go(2'b11, 1'b1);
    $display("mid-run reset test done");
    end_of_test();
  end
endmodule
